/* File: logic/racc_pkg.sv */
// Constants and types of the auxiliary configuration command handler
package racc_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned BAUD_RATE = 9600;
   localparam int unsigned BIT_CYC = CLK_HZ / BAUD_RATE;
   localparam int unsigned BIT_CNT_W = 12;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned STOP_BITS = 1;
   localparam int unsigned KEEPALIVE_S = 180;
   localparam int unsigned IDLE_S = 170;
   localparam int unsigned IDLE_CYC = CLK_HZ * IDLE_S;
   localparam int unsigned IDLE_W = 32;
   localparam int unsigned FIELD_CHARS = 20;
   localparam int unsigned MASK_HI = 0;
   localparam int unsigned ADDR_HI = 2;
   localparam int unsigned DATA_HI = 4;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_1 = 8'h31;
   localparam logic [7:0] CH_2 = 8'h32;
   localparam logic [7:0] CH_3 = 8'h33;
   localparam logic [7:0] CH_6 = 8'h36;
   localparam logic [7:0] CH_7 = 8'h37;
   localparam logic [7:0] CH_8 = 8'h38;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_F = 8'h46;
   localparam logic [7:0] CH_LA = 8'h61;
   localparam logic [7:0] CH_LF = 8'h66;
   localparam logic [7:0] CH_HASH = 8'h23;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [3:0] HEX_A_VAL = 4'ha;
   localparam logic [1:0] REPORT_OFF = 2'h0;
   localparam logic [63:0] CMP_BYTES_RST = 64'h0;
   localparam logic [7:0] MASK_RST = 8'h0;
   localparam logic [7:0] ADDR_RST = 8'h0;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_D1 = 6'h02,
      ST_D2 = 6'h04,
      ST_D3 = 6'h08,
      ST_FIELD = 6'h10,
      ST_SKIP = 6'h20
   } racc_state_t;
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_FILTER = 2'h1,
      CMD_INPUT = 2'h2,
      CMD_STATUS = 2'h3
   } racc_cmd_t;
endpackage

/* File: logic/racc_cmd.sv */
// Command parser, filter storage, input change and keep-alive generator
//
// Overview of operation
// - Filter command: code, two mask chars, two address chars, sixteen data chars.
// - Mask bit 7 selects first compare byte, bit 0 selects the eighth.
// - Two-bit report option: 820 off (default), 821 a, 822 b, 823 both.
// - Change on a watched input makes a status message on tag report path.
// - With auxiliary info on, report carries current sampled sense inputs.
// - Command 830 turns periodic status report off; off is the default.
// - Command 831 enables status report after an idle interval without messages.
// - Idle interval keeps host message gap under three minutes.
// - Serial link framing is 9600 baud, 8N1, no flow control.
`timescale 1ns/1ns
module racc_cmd
   import racc_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic [7:0] RX_CHAR_I,
   input wire logic RX_VALID_I,
   input wire logic SENSE_IN_A_I,
   input wire logic SENSE_IN_B_I,
   input wire logic AUX_INFO_EN_I,
   input wire logic MSG_SENT_I,
   output logic [7:0] COMPARE_BYTE_MASK_O,
   output logic [7:0] COMPARE_START_ADDR_O,
   output logic [63:0] COMPARE_BYTES_O,
   output logic [1:0] INPUT_REPORT_SEL_O,
   output logic STATUS_REPORT_EN_O,
   output logic [1:0] SENSE_STATUS_O,
   output logic INPUT_CHANGE_REQ_O,
   output logic STATUS_REPORT_REQ_O,
   output logic DONE_O,
   output logic ERROR_O,
   output logic [15:0] BAUD_DIV_O
);
   import racc_pkg::*;

   // Serial framing is fixed; the UART that uses these lives outside
   assign BAUD_DIV_O = 16'(BIT_CYC);

   racc_state_t state, next_state;
   racc_cmd_t cmd, next_cmd;
   logic [4:0] cnt, next_cnt;
   logic bad, next_bad;
   logic [79:0] shreg, next_shreg;
   logic [7:0] mask, next_mask;
   logic [7:0] addr, next_addr;
   logic [63:0] cmp, next_cmp;
   logic [1:0] rsel, next_rsel;
   logic sten, next_sten;
   logic done, next_done;
   logic err, next_err;
   logic [2:0] sync_a, sync_b;
   logic [1:0] seen, next_seen;
   logic [1:0] sense_out, next_sense_out;
   logic chg, next_chg;
   logic [IDLE_W-1:0] idle, next_idle;
   logic keep, next_keep;
   logic [1:0] sense_now;
   logic is_hex;
   logic [3:0] hex_val;
   logic eol;

   always_comb begin
      is_hex = 1'b1;
      hex_val = 4'h0;
      if (RX_CHAR_I >= CH_0 && RX_CHAR_I <= CH_9) begin
         hex_val = 4'(RX_CHAR_I - CH_0);
      end else if (RX_CHAR_I >= CH_A && RX_CHAR_I <= CH_F) begin
         hex_val = 4'(RX_CHAR_I - CH_A) + HEX_A_VAL;
      end else if (RX_CHAR_I >= CH_LA && RX_CHAR_I <= CH_LF) begin
         hex_val = 4'(RX_CHAR_I - CH_LA) + HEX_A_VAL;
      end else begin
         is_hex = 1'b0;
      end
   end

   assign eol = (RX_CHAR_I == CH_CR);

   // Command parser: '#' opens a command, carriage return closes it
   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_cnt = cnt;
      next_bad = bad;
      next_shreg = shreg;
      next_mask = mask;
      next_addr = addr;
      next_cmp = cmp;
      next_rsel = rsel;
      next_sten = sten;
      next_done = 1'b0;
      next_err = 1'b0;
      if (RX_VALID_I) begin
         if (RX_CHAR_I == CH_HASH) begin
            next_state = ST_D1;
            next_cmd = CMD_NONE;
            next_cnt = 5'h0;
            next_bad = 1'b0;
         end else begin
            unique case (state)
               ST_IDLE: begin
               end
               ST_D1: begin
                  next_state = (RX_CHAR_I == CH_6 || RX_CHAR_I == CH_8) ? ST_D2 : ST_SKIP;
                  next_cmd = (RX_CHAR_I == CH_6) ? CMD_FILTER : CMD_INPUT;
               end
               ST_D2: begin
                  next_state = ST_SKIP;
                  if (cmd == CMD_FILTER && RX_CHAR_I == CH_9) begin
                     next_state = ST_D3;
                  end else if (cmd == CMD_INPUT && RX_CHAR_I == CH_2) begin
                     next_state = ST_FIELD;
                  end else if (cmd == CMD_INPUT && RX_CHAR_I == CH_3) begin
                     next_state = ST_FIELD;
                     next_cmd = CMD_STATUS;
                  end
               end
               ST_D3: begin
                  next_state = (RX_CHAR_I == CH_7) ? ST_FIELD : ST_SKIP;
               end
               ST_FIELD: begin
                  if (eol) begin
                     next_state = ST_IDLE;
                     if (cmd == CMD_FILTER) begin
                        if (!bad && cnt == 5'(FIELD_CHARS)) begin
                           next_mask = shreg[79:72];
                           next_addr = shreg[71:64];
                           // Byte 0 (first sent) sits in the top lane so mask
                           // bit 7 and byte lane 7 line up
                           next_cmp = shreg[63:0];
                           next_done = 1'b1;
                        end else begin
                           next_err = 1'b1;
                        end
                     end else if (cmd == CMD_INPUT) begin
                        if (!bad && cnt == 5'h1 && shreg[3:2] == 2'h0) begin
                           next_rsel = shreg[1:0];
                           next_done = 1'b1;
                        end else begin
                           next_err = 1'b1;
                        end
                     end else begin
                        if (!bad && cnt == 5'h1 && shreg[3:1] == 3'h0) begin
                           next_sten = shreg[0];
                           next_done = 1'b1;
                        end else begin
                           next_err = 1'b1;
                        end
                     end
                  end else if (RX_CHAR_I != CH_SP) begin
                     if (!is_hex) begin
                        next_bad = 1'b1;
                     end
                     if (cnt != 5'(FIELD_CHARS)) begin
                        next_cnt = cnt + 5'h1;
                     end else begin
                        next_bad = 1'b1;
                     end
                     next_shreg = {shreg[75:0], hex_val};
                  end
               end
               ST_SKIP: begin
                  // Other command groups belong to other handlers
                  if (eol) begin
                     next_state = ST_IDLE;
                  end
               end
               default: begin
                  next_state = ST_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
         cmd <= CMD_NONE;
         cnt <= 5'h0;
         bad <= 1'b0;
         shreg <= 80'h0;
         mask <= MASK_RST;
         addr <= ADDR_RST;
         cmp <= CMP_BYTES_RST;
         rsel <= REPORT_OFF;
         sten <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         cnt <= next_cnt;
         bad <= next_bad;
         shreg <= next_shreg;
         mask <= next_mask;
         addr <= next_addr;
         cmp <= next_cmp;
         rsel <= next_rsel;
         sten <= next_sten;
         done <= next_done;
         err <= next_err;
      end
   end

   // Sense inputs: three stages, a change counts when stages two and three agree
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {sync_a[1:0], SENSE_IN_A_I};
         sync_b <= {sync_b[1:0], SENSE_IN_B_I};
      end
   end

   always_comb begin
      sense_now = seen;
      if (sync_a[1] == sync_a[2]) begin
         sense_now[0] = sync_a[2];
      end
      if (sync_b[1] == sync_b[2]) begin
         sense_now[1] = sync_b[2];
      end
      next_seen = sense_now;
      // Only watched inputs raise a report; the selection taking effect now decides,
      // so a report never comes out just after reporting was switched off
      next_chg = |((sense_now ^ seen) & next_rsel);
      next_sense_out = AUX_INFO_EN_I ? sense_now : 2'h0;
   end

   // Keep-alive timer; margin below three minutes covers report queueing
   always_comb begin
      next_idle = idle;
      next_keep = 1'b0;
      // A disable arriving in the same cycle must not let one last report out
      if (!sten || !next_sten || MSG_SENT_I || INPUT_CHANGE_REQ_O) begin
         next_idle = '0;
      end else if (idle == IDLE_W'(IDLE_CYC - 1)) begin
         next_idle = '0;
         next_keep = 1'b1;
      end else begin
         next_idle = idle + 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         seen <= 2'h0;
         sense_out <= 2'h0;
         chg <= 1'b0;
         idle <= '0;
         keep <= 1'b0;
      end else begin
         seen <= next_seen;
         sense_out <= next_sense_out;
         chg <= next_chg;
         idle <= next_idle;
         keep <= next_keep;
      end
   end

   assign COMPARE_BYTE_MASK_O = mask;
   assign COMPARE_START_ADDR_O = addr;
   assign COMPARE_BYTES_O = cmp;
   assign INPUT_REPORT_SEL_O = rsel;
   assign STATUS_REPORT_EN_O = sten;
   assign SENSE_STATUS_O = sense_out;
   assign INPUT_CHANGE_REQ_O = chg;
   assign STATUS_REPORT_REQ_O = keep;
   assign DONE_O = done;
   assign ERROR_O = err;
endmodule

/* File: dv/racc_cmd_sva.sv */
// Checker of the command handler outputs
`timescale 1ns/1ns
module racc_cmd_sva
   import racc_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic AUX_INFO_EN_I,
   input wire logic MSG_SENT_I,
   input wire logic [7:0] COMPARE_BYTE_MASK_O,
   input wire logic [7:0] COMPARE_START_ADDR_O,
   input wire logic [63:0] COMPARE_BYTES_O,
   input wire logic [1:0] INPUT_REPORT_SEL_O,
   input wire logic STATUS_REPORT_EN_O,
   input wire logic [1:0] SENSE_STATUS_O,
   input wire logic INPUT_CHANGE_REQ_O,
   input wire logic STATUS_REPORT_REQ_O,
   input wire logic DONE_O,
   input wire logic ERROR_O,
   input wire logic [15:0] BAUD_DIV_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);
   a_done_err_excl: assert property (!(DONE_O && ERROR_O))
      else $error("done and error together");
   a_filter_on_done: assert property ($changed({COMPARE_BYTE_MASK_O, COMPARE_START_ADDR_O,
      COMPARE_BYTES_O}) |-> DONE_O)
      else $error("filter changed without done");
   a_sel_on_done: assert property ($changed(INPUT_REPORT_SEL_O) |-> DONE_O)
      else $error("report select changed without done");
   a_en_on_done: assert property ($changed(STATUS_REPORT_EN_O) |-> DONE_O)
      else $error("status enable changed without done");
   a_done_one_cycle: assert property (DONE_O |=> !DONE_O)
      else $error("done longer than one cycle");
   a_keepalive_gated: assert property (STATUS_REPORT_REQ_O |-> STATUS_REPORT_EN_O)
      else $error("status report while disabled");
   a_sent_restarts: assert property (MSG_SENT_I |=> !STATUS_REPORT_REQ_O)
      else $error("status report right after a message");
   a_change_watched: assert property (INPUT_CHANGE_REQ_O |-> INPUT_REPORT_SEL_O != 2'h0)
      else $error("input change with reporting off");
   a_sense_masked: assert property (!AUX_INFO_EN_I [*2] |-> SENSE_STATUS_O == 2'h0)
      else $error("sense status without aux info");
   a_baud_const: assert property (BAUD_DIV_O == 16'h0823)
      else $error("baud divider wrong");
endmodule

/* File: dv/racc_host.sv */
// Host model sending command characters to the reader
`timescale 1ns/1ns
module racc_host (
   input wire logic clk_i,
   output logic [7:0] rx_char_o,
   output logic rx_valid_o
);
   initial begin
      rx_char_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   // Whole 8-bit chars back to back; idle line shows the inverse, not a stale char
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clk_i);
         rx_char_o <= s[i];
         rx_valid_o <= 1'b1;
      end
      @(posedge clk_i);
      rx_char_o <= ~s[s.len()-1];
      rx_valid_o <= 1'b0;
   endtask
endmodule

/* File: dv/racc_cmd_test.sv */
// Testbench of the auxiliary configuration command handler
`timescale 1ns/1ns
module racc_cmd_test;
   import racc_pkg::*;
   logic CLK_SYS_I = 1'b0;
   logic RESETN_I = 1'b0;
   logic SENSE_IN_A_I = 1'b0;
   logic SENSE_IN_B_I = 1'b0;
   logic AUX_INFO_EN_I = 1'b0;
   logic MSG_SENT_I = 1'b0;
   logic [7:0] RX_CHAR_I;
   logic RX_VALID_I;
   logic [7:0] mask;
   logic [7:0] addr;
   logic [63:0] bytes;
   logic [1:0] sel;
   logic en;
   logic [1:0] sense;
   logic chg;
   logic keep;
   logic DONE_O;
   logic ERROR_O;
   logic [15:0] baud;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   logic keep_hit = 1'b0;
   logic [7:0] tag_mem [0:255];
   // Tag side of the filter: byte i meets memory at start plus i, masked bytes only
   function automatic logic tag_match(input logic [7:0] m, input logic [7:0] a,
      input logic [63:0] d);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (m[7-i] && tag_mem[8'(a + i)] != d[63-8*i -: 8]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction
   always #25 CLK_SYS_I = ~CLK_SYS_I;
   racc_host u_host (.clk_i(CLK_SYS_I), .rx_char_o(RX_CHAR_I), .rx_valid_o(RX_VALID_I));
   racc_cmd u_dut (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .RX_CHAR_I(RX_CHAR_I),
      .RX_VALID_I(RX_VALID_I), .SENSE_IN_A_I(SENSE_IN_A_I), .SENSE_IN_B_I(SENSE_IN_B_I),
      .AUX_INFO_EN_I(AUX_INFO_EN_I), .MSG_SENT_I(MSG_SENT_I), .COMPARE_BYTE_MASK_O(mask),
      .COMPARE_START_ADDR_O(addr), .COMPARE_BYTES_O(bytes), .INPUT_REPORT_SEL_O(sel),
      .STATUS_REPORT_EN_O(en), .SENSE_STATUS_O(sense), .INPUT_CHANGE_REQ_O(chg),
      .STATUS_REPORT_REQ_O(keep), .DONE_O(DONE_O), .ERROR_O(ERROR_O), .BAUD_DIV_O(baud));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cmd(input string s, input logic ok);
      int n;
      n = 0;
      u_host.send(s);
      #1;
      while (DONE_O !== 1'b1 && ERROR_O !== 1'b1 && n < 4) begin
         @(posedge CLK_SYS_I);
         #1;
         n++;
      end
      chk("answer", {DONE_O, ERROR_O}, ok ? 2'b10 : 2'b01);
   endtask
   // Sense path has a synchroniser, so allow several cycles for the pulse
   task automatic watch(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge CLK_SYS_I);
         #1;
         if (chg === 1'b1) seen = 1'b1;
      end
      chk("input_change", seen, exp);
   endtask
   always @(posedge CLK_SYS_I) begin
      cyc++;
      // The run is far shorter than the idle interval, so no keep-alive may appear
      if (keep === 1'b1) keep_hit <= 1'b1;
      if (cyc == 5000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) tag_mem[i] = 8'hff;
      tag_mem[8'h0a] = 8'h00;
      tag_mem[8'h0c] = 8'h01;
      tag_mem[8'h0f] = 8'h02;
      repeat (4) @(posedge CLK_SYS_I);
      RESETN_I <= 1'b1;
      #1;
      chk("reset_cfg", {mask, addr, sel, en}, 0);
      chk("reset_bytes", bytes, 0);
      chk("baud", baud, 16'h0823);
      chk("idle_bound", IDLE_S < 32'hb4, 1);
      cmd("#697 A4 0A 0005014202024133\r", 1'b1);
      chk("mask", mask, 8'ha4);
      chk("addr", addr, 8'h0a);
      chk("bytes", bytes, 64'h0005014202024133);
      chk("tag_match", tag_match(mask, addr, bytes), 1'b1);
      tag_mem[8'h0f] = 8'h03;
      chk("tag_miss", tag_match(mask, addr, bytes), 1'b0);
      cmd("#697ff01000000000000000G\r", 1'b0);
      chk("kept_cfg", {mask, addr}, 16'ha40a);
      chk("kept_bytes", bytes, 64'h0005014202024133);
      for (int n = 0; n < 4; n++) begin
         cmd($sformatf("#82%0d\r", n), 1'b1);
         chk("sel", sel, n);
      end
      cmd("#824\r", 1'b0);
      chk("sel_kept", sel, 2'h3);
      @(posedge CLK_SYS_I);
      AUX_INFO_EN_I <= 1'b1;
      SENSE_IN_A_I <= 1'b1;
      watch(1'b1);
      chk("sense", sense, 2'b01);
      cmd("#821\r", 1'b1);
      @(posedge CLK_SYS_I);
      SENSE_IN_B_I <= 1'b1;
      watch(1'b0);
      chk("sense", sense, 2'b11);
      @(posedge CLK_SYS_I);
      AUX_INFO_EN_I <= 1'b0;
      repeat (3) @(posedge CLK_SYS_I);
      #1;
      chk("sense_off", sense, 2'b00);
      cmd("#831\r", 1'b1);
      chk("status_en", en, 1'b1);
      cmd("#832\r", 1'b0);
      chk("en_kept", en, 1'b1);
      @(posedge CLK_SYS_I);
      MSG_SENT_I <= 1'b1;
      @(posedge CLK_SYS_I);
      MSG_SENT_I <= 1'b0;
      cmd("#830\r", 1'b1);
      chk("status_en", en, 1'b0);
      chk("keepalive_early", keep_hit, 1'b0);
      stop_test();
   end
endmodule
bind racc_cmd racc_cmd_sva u_sva (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
   .AUX_INFO_EN_I(AUX_INFO_EN_I), .MSG_SENT_I(MSG_SENT_I),
   .COMPARE_BYTE_MASK_O(COMPARE_BYTE_MASK_O), .COMPARE_START_ADDR_O(COMPARE_START_ADDR_O),
   .COMPARE_BYTES_O(COMPARE_BYTES_O), .INPUT_REPORT_SEL_O(INPUT_REPORT_SEL_O),
   .STATUS_REPORT_EN_O(STATUS_REPORT_EN_O), .SENSE_STATUS_O(SENSE_STATUS_O),
   .INPUT_CHANGE_REQ_O(INPUT_CHANGE_REQ_O), .STATUS_REPORT_REQ_O(STATUS_REPORT_REQ_O),
   .DONE_O(DONE_O), .ERROR_O(ERROR_O), .BAUD_DIV_O(BAUD_DIV_O));
